// ### logic/quart_bus_if.sv
`timescale 1ns/10ps
interface quart_bus_if;
    logic       bus_style;
    logic       interrupt_output_select;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic [3:0] chip_select_n;
    logic [2:0] addr;
    logic [7:0] data_from_host;
    logic       data_from_host_oe_n;
    logic [7:0] data_from_dev;
    logic       data_from_dev_oe_n;
    logic [3:0] chan_irq_out;
    logic [3:0] chan_irq_oe_n;
    logic       shared_irq_out;
    logic       shared_irq_oe_n;
    modport dev (
        input  bus_style, interrupt_output_select, read_strobe_n, write_strobe_n,
        input  chip_select_n, addr, data_from_host, data_from_host_oe_n,
        output data_from_dev, data_from_dev_oe_n, chan_irq_out, chan_irq_oe_n,
        output shared_irq_out, shared_irq_oe_n
    );
    modport host (
        output bus_style, interrupt_output_select, read_strobe_n, write_strobe_n,
        output chip_select_n, addr, data_from_host, data_from_host_oe_n,
        input  data_from_dev, data_from_dev_oe_n, chan_irq_out, chan_irq_oe_n,
        input  shared_irq_out, shared_irq_oe_n
    );
endinterface

// ### logic/quart_bus_pkg.sv
package quart_bus_pkg;
    localparam int CHANNELS   = 4;
    localparam int ADDR_W     = 3;
    localparam int DATA_W     = 8;
    localparam int REGS       = 8;
    // bus style select level: high = strobe style, low = alternate
    localparam logic MODE_STROBE = 1'b1;
    localparam logic MODE_ALT    = 1'b0;
    // position of the interrupt output gate bit in each channel's modem control register
    localparam int GATE_REG   = 4;
    localparam int GATE_BIT   = 3;
    localparam int IRQ_EN_REG = 1;
    localparam logic [7:0] REG_RESET = 8'h00;
    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_ACTIVE,
        HOST_RELEASE
    } host_state_t;
endpackage

// ### logic/quart_host_cpu_end.sv
`timescale 1ns/10ps
module quart_host_cpu_end (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    quart_bus_if.host       bus,
    input  wire logic       mode_strobe,
    input  wire logic       int_select,
    input  wire logic       req_valid,
    input  wire logic       req_write,
    input  wire logic [1:0] req_chan,
    input  wire logic [2:0] req_addr,
    input  wire logic [7:0] req_wdata,
    output logic            req_ready,
    output logic            rsp_valid,
    output logic [7:0]      rsp_rdata,
    output logic            irq_seen
);
    quart_bus_pkg::host_state_t st, next_st;
    logic       rs_n, next_rs_n, ws_n, next_ws_n, dq_oe_n, next_dq_oe_n;
    logic [3:0] cs_n, next_cs_n;
    logic [2:0] a, next_a;
    logic [7:0] dq, next_dq, rd, next_rd;
    logic       wr, next_wr, rdy, next_rdy, rv, next_rv, irq, next_irq;

    always_comb begin
        next_st = st; next_rs_n = 1'b1; next_ws_n = mode_strobe ? 1'b1 : ws_n;
        next_cs_n = 4'hf; next_a = a; next_dq = dq; next_dq_oe_n = 1'b1;
        next_rd = rd; next_wr = wr; next_rdy = 1'b0; next_rv = 1'b0;
        // read: a driven low shared request, any driven high channel output, or in strobe mode a driven high shared pin means service
        next_irq = (!bus.shared_irq_oe_n && !bus.shared_irq_out)
            || (|(bus.chan_irq_out & ~bus.chan_irq_oe_n))
            || (mode_strobe && !bus.shared_irq_oe_n && bus.shared_irq_out);
        case (st)
            quart_bus_pkg::HOST_IDLE: begin
                next_rdy = 1'b1;
                if (req_valid && rdy) begin
                    next_st = quart_bus_pkg::HOST_ACTIVE; next_rdy = 1'b0;
                    next_a = req_addr; next_wr = req_write; next_dq = req_wdata;
                    next_cs_n = ~(4'h1 << req_chan);
                    next_dq_oe_n = !req_write;
                    if (mode_strobe) begin
                        next_rs_n = req_write; next_ws_n = !req_write;
                    end else begin
                        next_rs_n = 1'b0; next_ws_n = !req_write;
                    end
                end
            end
            quart_bus_pkg::HOST_ACTIVE: begin
                next_cs_n = cs_n; next_rs_n = rs_n; next_ws_n = ws_n; next_dq_oe_n = dq_oe_n;
                next_st = quart_bus_pkg::HOST_RELEASE;
            end
            quart_bus_pkg::HOST_RELEASE: begin
                next_rd = bus.data_from_dev; next_rv = !wr;
                next_st = quart_bus_pkg::HOST_IDLE;
            end
            default: next_st = quart_bus_pkg::HOST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= quart_bus_pkg::HOST_IDLE; rs_n <= 1'b1; ws_n <= 1'b1; cs_n <= 4'hf; a <= 3'h0;
            dq <= 8'h00; dq_oe_n <= 1'b1; rd <= 8'h00; wr <= 1'b0; rdy <= 1'b0;
            rv <= 1'b0; irq <= 1'b0;
        end else begin
            st <= next_st; rs_n <= next_rs_n; ws_n <= next_ws_n; cs_n <= next_cs_n;
            a <= next_a; dq <= next_dq; dq_oe_n <= next_dq_oe_n; rd <= next_rd;
            wr <= next_wr; rdy <= next_rdy; rv <= next_rv; irq <= next_irq;
        end
    end

    always_comb begin
        bus.bus_style = mode_strobe;
        bus.interrupt_output_select = int_select;
        bus.read_strobe_n = rs_n;
        bus.write_strobe_n = ws_n;
        bus.chip_select_n = cs_n;
        bus.addr = a;
        bus.data_from_host = dq;
        bus.data_from_host_oe_n = dq_oe_n;
        req_ready = rdy;
        rsp_valid = rv;
        rsp_rdata = rd;
        irq_seen = irq;
    end
endmodule

// ### logic/quart_host_strobe_irq_ctrl.sv
// What this block does
// - select high forces interrupt outputs enabled
// - select low lets gate bit enable outputs
// - select active high, defaults low
// - select ignored in alternate bus mode
// - read strobe low drives addressed register
// - write strobe low captures bus into register
// - alternate mode: write strobe is direction
// - alternate mode: channel requests ORed together
// - alternate mode: shared request low when enabled condition pending
// - alternate mode: shared request only pulls low, else floats
// - host polls channels to find requester
// - strobe mode: shared pin is first channel output
// - bus style low alternate, high strobe
// - channel output needs gate, enable, condition
`timescale 1ns/10ps
module quart_host_strobe_irq_ctrl #(
    parameter int CHANNELS = quart_bus_pkg::CHANNELS
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    quart_bus_if.dev                 bus,
    input  wire logic [CHANNELS-1:0] chan_condition,
    output logic [CHANNELS-1:0][7:0] chan_irq_enable_reg,
    output logic [CHANNELS-1:0]      chan_gate_bit
);
    logic [7:0] regs      [CHANNELS][quart_bus_pkg::REGS];
    logic [7:0] next_regs [CHANNELS][quart_bus_pkg::REGS];
    logic [7:0]          data_out;
    logic [7:0]          next_data_out;
    logic                data_oe_n;
    logic                next_data_oe_n;
    logic [CHANNELS-1:0] irq_val;
    logic [CHANNELS-1:0] next_irq_val;
    logic [CHANNELS-1:0] irq_oe_n;
    logic [CHANNELS-1:0] next_irq_oe_n;
    logic                shr_val;
    logic                next_shr_val;
    logic                shr_oe_n;
    logic                next_shr_oe_n;
    logic                wr_d;
    logic                next_wr_d;
    logic                strobe_mode;
    logic                sel;
    logic                rd_req;
    logic                wr_req;
    logic [CHANNELS-1:0] pend;

    function automatic logic chan_hit(input logic [3:0] cs_n, input int ch);
        chan_hit = !cs_n[ch];
    endfunction

    // any set enable bit lets the condition through
    function automatic logic irq_enabled(input logic [7:0] en);
        irq_enabled = (en != 8'h00);
    endfunction

    always_comb begin
        strobe_mode = (bus.bus_style == quart_bus_pkg::MODE_STROBE);
        // an undriven select reads as unknown and is taken as low
        sel = strobe_mode && (bus.interrupt_output_select === 1'b1);
    end

    // alternate mode: write strobe is r/w (1 read, 0 write), read strobe low qualifies
    always_comb begin
        if (strobe_mode) begin
            rd_req = !bus.read_strobe_n;
            wr_req = !bus.write_strobe_n;
        end else begin
            rd_req = !bus.read_strobe_n && bus.write_strobe_n;
            wr_req = !bus.read_strobe_n && !bus.write_strobe_n;
        end
    end

    // a held strobe writes once: only its first cycle counts
    always_comb begin
        next_wr_d = wr_req;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_d <= 1'b0;
        end else begin
            wr_d <= next_wr_d;
        end
    end

    always_comb begin
        next_regs = regs;
        for (int c = 0; c < CHANNELS; c++) begin
            if (chan_hit(bus.chip_select_n, c) && wr_req && !wr_d) begin
                next_regs[c][bus.addr] = bus.data_from_host;
            end
        end
    end

    // reset clears every register of every channel, gate bits included
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int c = 0; c < CHANNELS; c++) begin
                for (int r = 0; r < quart_bus_pkg::REGS; r++) begin
                    regs[c][r] <= quart_bus_pkg::REG_RESET;
                end
            end
        end else begin
            regs <= next_regs;
        end
    end

    // only a selected channel answers; without a chip select the bus stays undriven
    always_comb begin
        next_data_out = 8'h00;
        next_data_oe_n = 1'b1;
        for (int c = 0; c < CHANNELS; c++) begin
            if (chan_hit(bus.chip_select_n, c) && rd_req) begin
                next_data_out = regs[c][bus.addr];
                next_data_oe_n = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end else begin
            data_out <= next_data_out;
            data_oe_n <= next_data_oe_n;
        end
    end

    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            pend[c] = chan_condition[c] && irq_enabled(regs[c][quart_bus_pkg::IRQ_EN_REG]);
            next_irq_val[c] = pend[c];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_val <= '0;
        end else begin
            irq_val <= next_irq_val;
        end
    end

    // select high overrides the gate bit; both are dead in alternate mode
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            next_irq_oe_n[c] = !(strobe_mode &&
                (sel || regs[c][quart_bus_pkg::GATE_REG][quart_bus_pkg::GATE_BIT]));
        end
    end

    // enables leave reset off so no pin is driven before software asks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_oe_n <= '1;
        end else begin
            irq_oe_n <= next_irq_oe_n;
        end
    end

    always_comb begin
        if (strobe_mode) begin
            next_shr_val = next_irq_val[0];
            next_shr_oe_n = next_irq_oe_n[0];
        end else begin
            // only ever pulls low; the high level is left to an outside pull-up
            next_shr_val = 1'b0;
            next_shr_oe_n = !(|pend);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shr_val <= 1'b0;
        end else begin
            shr_val <= next_shr_val;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            shr_oe_n <= 1'b1;
        end else begin
            shr_oe_n <= next_shr_oe_n;
        end
    end

    always_comb begin
        bus.data_from_dev = data_out;
        bus.data_from_dev_oe_n = data_oe_n;
        // channel 0 has no pin of its own: it leaves by the shared pin
        bus.chan_irq_out = {irq_val[3:1], 1'b0};
        bus.chan_irq_oe_n = {irq_oe_n[3:1], 1'b1};
        bus.shared_irq_out = shr_val;
        bus.shared_irq_oe_n = shr_oe_n;
    end

    // register view for the datapath side, straight from the register flops
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            chan_irq_enable_reg[c] = regs[c][quart_bus_pkg::IRQ_EN_REG];
            chan_gate_bit[c] = regs[c][quart_bus_pkg::GATE_REG][quart_bus_pkg::GATE_BIT];
        end
    end
endmodule

// ### tb/quart_bus_checker.sv
`timescale 1ns/10ps
module quart_bus_checker (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       bus_style,
    input wire logic       interrupt_output_select,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic [3:0] chip_select_n,
    input wire logic       data_from_dev_oe_n,
    input wire logic [3:0] chan_irq_oe_n,
    input wire logic       shared_irq_out,
    input wire logic       shared_irq_oe_n
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_rd;
        !(&chip_select_n) && !read_strobe_n && write_strobe_n;
    endsequence
    property p_sel_forces;
        bus_style && interrupt_output_select |=> chan_irq_oe_n[3:1] == 3'h0 && !shared_irq_oe_n;
    endproperty
    property p_alt_ignores;
        !bus_style && interrupt_output_select |=> chan_irq_oe_n == 4'hf;
    endproperty
    property p_pull_low;
        !bus_style |=> shared_irq_oe_n || !shared_irq_out;
    endproperty
    property p_rd_strobe;
        bus_style ##0 s_rd |=> !data_from_dev_oe_n;
    endproperty
    property p_rd_alt;
        !bus_style ##0 s_rd |=> !data_from_dev_oe_n;
    endproperty
    property p_no_rd;
        (bus_style && read_strobe_n) [*2] |=> data_from_dev_oe_n;
    endproperty
    property p_no_cs;
        (&chip_select_n) [*2] |=> data_from_dev_oe_n;
    endproperty
    property p_one_strobe;
        bus_style |-> read_strobe_n || write_strobe_n;
    endproperty
    a_sel_forces: assert property (p_sel_forces) else $error("select high left irq outputs off");
    a_alt_ignores: assert property (p_alt_ignores) else $error("select acted in alternate mode");
    a_pull_low: assert property (p_pull_low) else $error("shared request driven high");
    a_rd_strobe: assert property (p_rd_strobe) else $error("strobe read not answered");
    a_rd_alt: assert property (p_rd_alt) else $error("alternate read not answered");
    a_no_rd: assert property (p_no_rd) else $error("data driven without read");
    a_no_cs: assert property (p_no_cs) else $error("data driven without chip select");
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
endmodule

// ### tb/quart_host_strobe_irq_ctrl_tb.sv
`timescale 1ns/10ps
module quart_host_strobe_irq_ctrl_tb;
    logic            clk_sys = 1'b0;
    logic            rst = 1'b1;
    logic            mode_strobe = 1'b1;
    logic            int_select = 1'b0;
    logic            req_valid = 1'b0;
    logic            req_write = 1'b0;
    logic [1:0]      req_chan = 2'h0;
    logic [2:0]      req_addr = 3'h0;
    logic [7:0]      req_wdata = 8'h00;
    logic [3:0]      chan_condition = 4'h0;
    logic            req_ready;
    logic            rsp_valid;
    logic [7:0]      rsp_rdata;
    logic [3:0][7:0] chan_irq_enable_reg;
    logic [3:0]      chan_gate_bit;
    logic            irq_seen;
    logic [3:0]      gate = 4'h0;
    logic [7:0]      q[$];
    int              n_fail = 0;
    int              checks_done = 0;
    int              cycles = 0;
    int              seed = 32'h8f12;
    quart_bus_if bus ();
    quart_host_strobe_irq_ctrl i_quart_host_strobe_irq_ctrl (.clk_sys(clk_sys), .rst(rst), .bus(bus),
        .chan_condition(chan_condition), .chan_irq_enable_reg(chan_irq_enable_reg), .chan_gate_bit(chan_gate_bit));
    quart_host_cpu_end i_quart_host_cpu_end (.clk_sys(clk_sys), .rst(rst), .bus(bus), .mode_strobe(mode_strobe),
        .int_select(int_select), .req_valid(req_valid), .req_write(req_write), .req_chan(req_chan),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .irq_seen(irq_seen));
    quart_bus_checker i_quart_bus_checker (.clk_sys(clk_sys), .rst(rst), .bus_style(bus.bus_style),
        .interrupt_output_select(bus.interrupt_output_select), .read_strobe_n(bus.read_strobe_n),
        .write_strobe_n(bus.write_strobe_n), .chip_select_n(bus.chip_select_n),
        .data_from_dev_oe_n(bus.data_from_dev_oe_n), .chan_irq_oe_n(bus.chan_irq_oe_n),
        .shared_irq_out(bus.shared_irq_out), .shared_irq_oe_n(bus.shared_irq_oe_n));
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // reads note their expected byte; the monitor below pops it
    task automatic access(input logic w, input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        while (req_ready !== 1'b1) @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_chan <= ch;
        req_addr <= a;
        req_wdata <= d;
        if (!w) q.push_back(d);
        @(posedge clk_sys);
        req_valid <= 1'b0;
    endtask
    task automatic check_pins(input logic [3:0] cond, input logic sel, input logic strobe);
        logic [3:0] oe;
        logic       soe;
        oe = strobe ? {~(gate[3:1] | {3{sel}}), 1'b1} : 4'hf;
        soe = strobe ? ~(sel | gate[0]) : ~(|cond);
        cmp("irq enables", {4'h0, oe}, {4'h0, bus.chan_irq_oe_n});
        cmp("irq levels", {4'h0, cond & ~oe}, {4'h0, bus.chan_irq_out & ~oe});
        cmp("shared enable", {7'h0, soe}, {7'h0, bus.shared_irq_oe_n});
        if (!soe) cmp("shared level", {7'h0, strobe & cond[0]}, {7'h0, bus.shared_irq_out});
        cmp("irq seen", {7'h0, strobe ? |(cond & ~{oe[3:1], soe}) : |cond}, {7'h0, irq_seen});
    endtask
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (rsp_valid === 1'b1) cmp("read data", q.size() ? q.pop_front() : 8'hxx, rsp_rdata);
        if (cycles == 3000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        logic [7:0] d;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        // upper half of the loop runs the register traffic in alternate mode
        for (int i = 0; i < 8; i++) begin
            mode_strobe <= ~i[2];
            d = 8'($random(seed));
            access(1'b1, i[1:0], 3'h1, d | 8'h01);
            access(1'b1, i[1:0], 3'h4, d);
            access(1'b0, i[1:0], 3'h1, d | 8'h01);
            access(1'b0, i[1:0], 3'h4, d);
            gate[i[1:0]] = d[3];
            cmp("enable reg", d | 8'h01, chan_irq_enable_reg[i[1:0]]);
            cmp("gate bit", {7'h0, d[3]}, {7'h0, chan_gate_bit[i[1:0]]});
        end
        for (int i = 0; i < 16; i++) begin
            {mode_strobe, int_select} <= i[1:0];
            chan_condition <= 4'($random(seed));
            repeat (4) @(posedge clk_sys);
            check_pins(chan_condition, int_select, mode_strobe);
        end
        repeat (8) @(posedge clk_sys);
        cmp("reads left", 8'h00, 8'(q.size()));
        conclude();
    end
endmodule
